// ---- design/sebp_port.sv ----
// Shared external bus port: master access engine, slave access to internal memory
`timescale 1ns/10ps
module sebp_port
    import sebp_pkg::*;
#(
    parameter int MEM_AW = 8
) (
    input  wire logic              ref_clk_i,
    input  wire logic              resetn_i,
    input  wire logic              bus_master_i,
    input  wire sebp_sysctl_t      system_control_setting_i,
    input  wire sebp_fmt_t         slave_fmt_i,
    input  wire sebp_req_t         req_i,
    output logic                   req_ready_o,
    output sebp_rsp_t              rsp_o,
    input  wire logic [ADDR_W-1:0] addr_i,
    output logic      [ADDR_W-1:0] addr_o,
    output logic                   addr_oe_o,
    input  wire logic [DATA_W-1:0] data_i,
    output logic      [DATA_W-1:0] data_o,
    output logic                   data_oe_o,
    output logic      [BANKS-1:0]  bank_select_n_o,
    output logic                   bank_select_oe_o,
    input  wire logic              rd_n_i,
    output logic                   rd_n_o,
    output logic                   rd_oe_o,
    input  wire logic              wr_n_i,
    output logic                   wr_n_o,
    output logic                   wr_oe_o,
    output logic                   page_o,
    output logic                   page_oe_o
);
    localparam int PIN_W = ADDR_W + DATA_W + 2;
    localparam logic [PIN_W-1:0] PIN_RST = {{(ADDR_W + DATA_W){1'b0}}, 2'b11};

    typedef enum {M_IDLE, M_STROBE, M_RECOVER} sebp_mst_t;

    sebp_mst_t          st_q;
    logic [3:0]         cnt_q;
    logic               wr_acc_q;
    sebp_fmt_t          fmt_q;
    logic [ADDR_W-1:0]  last_page_q;
    logic               last_page_vld_q;
    logic [PIN_W-1:0]   pins_s;
    logic [ADDR_W-1:0]  s_addr;
    logic [DATA_W-1:0]  s_data;
    logic               s_rd_n;
    logic               s_wr_n;
    logic               s_wr_prev_q;
    logic [ADDR_W-1:0]  s_waddr_q;
    logic [DATA_W-1:0]  s_wdata_q;
    logic               s_rd_q;
    logic               mem_we;
    logic [WORD_W-1:0]  mem_rdata;
    logic               acc_go;
    logic [BANKS-1:0]   bsel_dec;
    logic [ADDR_W-1:0]  page_num;
    logic               page_cross;

    function automatic logic [BANKS-1:0] bank_decode(logic [ADDR_W-1:0] a, sebp_sysctl_t sc);
        logic [ADDR_W-1:0] idx;
        idx = (a - sc.ext_base) >> sc.bank_shift;
        if (a < sc.ext_base || idx >= ADDR_W'(BANKS))
        begin
            return BSEL_IDLE;
        end
        return ~(BANKS'(1) << idx[1:0]);
    endfunction

    // Pins are driven by other parties on their own timing
    sebp_sync #(
        .W       (PIN_W),
        .RST_VAL (PIN_RST)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .d_i       ({addr_i, data_i, rd_n_i, wr_n_i}),
        .q_o       (pins_s)
    );

    assign {s_addr, s_data, s_rd_n, s_wr_n} = pins_s;

    assign acc_go     = (st_q == M_IDLE) && req_i.valid && req_ready_o && bus_master_i;
    assign bsel_dec   = bank_decode(req_i.addr, system_control_setting_i);
    assign page_num   = req_i.addr >> system_control_setting_i.page_shift;
    assign page_cross = !last_page_vld_q || (page_num != last_page_q);

    // Master sequencing
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_q     <= M_IDLE;
            cnt_q    <= '0;
            wr_acc_q <= 1'b0;
            fmt_q    <= FMT_W32;
        end
        else
        begin
            unique case (st_q)
                M_IDLE:
                begin
                    if (acc_go)
                    begin
                        st_q     <= M_STROBE;
                        cnt_q    <= 4'(STROBE_CYC);
                        wr_acc_q <= req_i.write;
                        fmt_q    <= req_i.fmt;
                    end
                end
                M_STROBE:
                begin
                    cnt_q <= cnt_q - CNT_W_ONE;
                    if (cnt_q == CNT_W_ONE)
                    begin
                        st_q <= M_RECOVER;
                    end
                end
                M_RECOVER:
                begin
                    st_q <= M_IDLE;
                end
            endcase
        end
    end

    // Only the bus holder drives address, selects and strobes
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            addr_oe_o        <= 1'b0;
            bank_select_oe_o <= 1'b0;
            rd_oe_o          <= 1'b0;
            wr_oe_o          <= 1'b0;
            page_oe_o        <= 1'b0;
        end
        else
        begin
            addr_oe_o        <= bus_master_i;
            bank_select_oe_o <= bus_master_i;
            rd_oe_o          <= bus_master_i;
            wr_oe_o          <= bus_master_i;
            page_oe_o        <= bus_master_i;
        end
    end

    // Address and bank selects move together; below ext_base no select fires,
    // which is the window onto other processors' internal memory
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            addr_o          <= '0;
            bank_select_n_o <= BSEL_IDLE;
        end
        else if (acc_go)
        begin
            addr_o          <= req_i.addr;
            bank_select_n_o <= bsel_dec;
        end
        else if (st_q == M_RECOVER || !bus_master_i)
        begin
            bank_select_n_o <= BSEL_IDLE;
        end
    end

    // A failed condition still selects the bank but never strobes
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
        end
        else if (acc_go)
        begin
            rd_n_o <= !(req_i.cond_true && !req_i.write);
            wr_n_o <= !(req_i.cond_true && req_i.write);
        end
        else if (st_q == M_STROBE && cnt_q == CNT_W_ONE)
        begin
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
        end
    end

    // DRAM page tracking applies to bank zero only
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            page_o          <= 1'b0;
            last_page_q     <= '0;
            last_page_vld_q <= 1'b0;
        end
        else if (acc_go && !bsel_dec[0])
        begin
            page_o          <= page_cross;
            last_page_q     <= page_num;
            last_page_vld_q <= 1'b1;
        end
        else if (st_q == M_RECOVER || acc_go || !bus_master_i)
        begin
            page_o <= 1'b0;
        end
    end

    // Data lanes: master write data, or slave read data for an outside reader
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            data_o    <= '0;
            data_oe_o <= 1'b0;
        end
        else if (acc_go)
        begin
            data_o    <= sebp_pack(req_i.fmt, req_i.wdata);
            data_oe_o <= req_i.write && req_i.cond_true;
        end
        else if (bus_master_i)
        begin
            if (st_q == M_STROBE && cnt_q == CNT_W_ONE)
            begin
                data_oe_o <= 1'b0;
            end
        end
        else
        begin
            data_o    <= sebp_pack(slave_fmt_i, mem_rdata);
            data_oe_o <= s_rd_q && !s_rd_n;
        end
    end

    // Read data are sampled late enough to cover the synchroniser delay
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rsp_o       <= '0;
            req_ready_o <= 1'b0;
        end
        else
        begin
            rsp_o.valid <= st_q == M_STROBE && cnt_q == CNT_W_ONE && !wr_acc_q;
            if (st_q == M_STROBE && cnt_q == CNT_W_ONE)
            begin
                rsp_o.rdata <= sebp_unpack(fmt_q, s_data);
            end
            req_ready_o <= (st_q == M_RECOVER) || (st_q == M_IDLE && !acc_go);
        end
    end

    // Slave side: sense strobes from whoever holds the bus
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_rd_q      <= 1'b0;
            s_wr_prev_q <= 1'b1;
            s_waddr_q   <= '0;
            s_wdata_q   <= '0;
        end
        else
        begin
            s_rd_q      <= !bus_master_i && !s_rd_n;
            s_wr_prev_q <= s_wr_n;
            if (!bus_master_i && !s_wr_n)
            begin
                s_waddr_q <= s_addr;
                s_wdata_q <= s_data;
            end
        end
    end

    // Commit on the strobe's rising edge so the writer's data has settled
    assign mem_we = !bus_master_i && s_wr_n && !s_wr_prev_q
                    && (s_waddr_q[ADDR_W-1:MEM_AW] == '0);

    sebp_mem #(
        .AW (MEM_AW),
        .DW (WORD_W)
    ) u_mem (
        .ref_clk_i (ref_clk_i),
        .we_i      (mem_we),
        .waddr_i   (s_waddr_q[MEM_AW-1:0]),
        .wdata_i   (sebp_unpack(slave_fmt_i, s_wdata_q)),
        .raddr_i   (s_addr[MEM_AW-1:0]),
        .rdata_o   (mem_rdata)
    );

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    property p_bsel_idle;
        st_q == M_IDLE && $past(st_q) == M_RECOVER |-> bank_select_n_o == BSEL_IDLE;
    endproperty
    a_bsel_idle: assert property (p_bsel_idle) else $error("bank select active when idle");

    property p_addr_bsel;
        acc_go |=> addr_o == $past(req_i.addr) && bank_select_n_o == $past(bsel_dec);
    endproperty
    a_addr_bsel: assert property (p_addr_bsel) else $error("address and select not together");

    property p_cond_false;
        acc_go && !req_i.cond_true && bsel_dec != BSEL_IDLE
            |=> bank_select_n_o != BSEL_IDLE && rd_n_o && wr_n_o;
    endproperty
    a_cond_false: assert property (p_cond_false) else $error("conditional access wrong");

    property p_rd_strobe;
        acc_go && !req_i.write && req_i.cond_true |=> !rd_n_o [*4] ##1 rd_n_o;
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe length wrong");

    property p_wr_strobe;
        acc_go && req_i.write && req_i.cond_true |=> !wr_n_o && data_oe_o && rd_n_o;
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe missing");

    property p_release;
        !bus_master_i |=> !bank_select_oe_o && !rd_oe_o && !wr_oe_o && !addr_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("non-master drives bus");

    property p_page_bank0;
        page_o |-> !bank_select_n_o[0];
    endproperty
    a_page_bank0: assert property (p_page_bank0) else $error("page outside bank zero");

    property p_lane_w32;
        acc_go && req_i.fmt == FMT_W32 |=> data_o[47:16] == $past(req_i.wdata[31:0]);
    endproperty
    a_lane_w32: assert property (p_lane_w32) else $error("32-bit lanes wrong");

    property p_lane_x40;
        acc_go && req_i.fmt == FMT_X40 |=> data_o[47:8] == $past(req_i.wdata);
    endproperty
    a_lane_x40: assert property (p_lane_x40) else $error("40-bit lanes wrong");

    property p_lane_s16;
        acc_go && req_i.fmt == FMT_S16 |=> data_o[31:16] == $past(req_i.wdata[15:0]);
    endproperty
    a_lane_s16: assert property (p_lane_s16) else $error("16-bit lanes wrong");

    property p_lane_b8;
        acc_go && req_i.fmt == FMT_B8 |=> data_o[23:16] == $past(req_i.wdata[7:0]);
    endproperty
    a_lane_b8: assert property (p_lane_b8) else $error("boot byte lanes wrong");

    property p_slave_drive;
        data_oe_o && !bus_master_i && !$past(bus_master_i) |-> $past(!s_rd_n, 2);
    endproperty
    a_slave_drive: assert property (p_slave_drive) else $error("slave drives unasked");

    c_read:  cover property (acc_go && !req_i.write ##5 rsp_o.valid);
    c_write: cover property (acc_go && req_i.write && req_i.cond_true);
    c_slave: cover property (mem_we ##[1:20] data_oe_o && !bus_master_i);
endmodule

// ---- pkg/sebp_pkg.sv ----
// Shared constants, types and lane helpers for the shared external bus port
package sebp_pkg;
    localparam int ADDR_W        = 32;
    localparam int DATA_W        = 48;
    localparam int WORD_W        = 40;
    localparam int BANKS         = 4;
    localparam int CLK_PERIOD_NS = 100;
    localparam int ACC_TIME_NS   = 200;
    localparam int ACC_CYC_RAW   = (ACC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC       = (ACC_CYC_RAW < 1) ? 1 : ACC_CYC_RAW;
    localparam int SYNC_DEPTH    = 2;
    localparam int STROBE_CYC    = ACC_CYC + SYNC_DEPTH;
    localparam int W32_LSB       = 16;
    localparam int X40_LSB       = 8;
    localparam int S16_LSB       = 16;
    localparam int B8_LSB        = 16;
    localparam int W32_W         = 32;
    localparam int S16_W         = 16;
    localparam int B8_W          = 8;
    localparam logic [BANKS-1:0] BSEL_IDLE = 4'hF;
    localparam logic [3:0]       CNT_W_ONE = 4'h1;

    typedef enum logic [1:0] {FMT_W32, FMT_X40, FMT_S16, FMT_B8} sebp_fmt_t;

    typedef struct packed {
        logic [4:0]        bank_shift;
        logic [4:0]        page_shift;
        logic [ADDR_W-1:0] ext_base;
    } sebp_sysctl_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic              cond_true;
        sebp_fmt_t         fmt;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } sebp_req_t;

    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] rdata;
    } sebp_rsp_t;

    function automatic logic [DATA_W-1:0] sebp_pack(sebp_fmt_t f, logic [WORD_W-1:0] w);
        logic [DATA_W-1:0] r;
        r = '0;
        unique case (f)
            FMT_W32: r[W32_LSB +: W32_W]  = w[W32_W-1:0];
            FMT_X40: r[X40_LSB +: WORD_W] = w;
            FMT_S16: r[S16_LSB +: S16_W]  = w[S16_W-1:0];
            FMT_B8:  r[B8_LSB +: B8_W]    = w[B8_W-1:0];
        endcase
        return r;
    endfunction

    function automatic logic [WORD_W-1:0] sebp_unpack(sebp_fmt_t f, logic [DATA_W-1:0] b);
        logic [WORD_W-1:0] w;
        w = '0;
        unique case (f)
            FMT_W32: w[W32_W-1:0] = b[W32_LSB +: W32_W];
            FMT_X40: w            = b[X40_LSB +: WORD_W];
            FMT_S16: w[S16_W-1:0] = b[S16_LSB +: S16_W];
            FMT_B8:  w[B8_W-1:0]  = b[B8_LSB +: B8_W];
        endcase
        return w;
    endfunction
endpackage

// ---- design/sebp_sync.sv ----
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module sebp_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         ref_clk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            meta_q <= RST_VAL;
            q_o    <= RST_VAL;
        end
        else
        begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

// ---- design/sebp_mem.sv ----
// Internal memory reachable by outside bus masters, registered read data
`timescale 1ns/10ps
module sebp_mem #(
    parameter int AW = 8,
    parameter int DW = 40
) (
    input  wire logic          ref_clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge ref_clk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

// ---- testbench/sebp_ext_mem.sv ----
// External memory model standing on the master side of the shared bus
`timescale 1ns/10ps
module sebp_ext_mem
    import sebp_pkg::*;
#(
    parameter int RD_DLY = 0
) (
    input  wire logic              ref_clk_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic              data_oe_i,
    input  wire logic              rd_n_i,
    input  wire logic              wr_n_i,
    output logic      [DATA_W-1:0] data_o
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] last_q = '0;
    int                rd_cnt = 0;

    // Whole bus word is stored, so lane placement is checked on the way back
    always @(posedge ref_clk_i)
    begin
        if (wr_n_i === 1'b0 && data_oe_i === 1'b1)
            mem[addr_i] = data_i;
        if (rd_n_i === 1'b0)
            last_q = data_o;
        rd_cnt = (rd_n_i === 1'b0) ? rd_cnt + 1 : 0;
    end

    // Released bus shows the inverse of its last value, never a kind constant
    always @(addr_i or rd_n_i or rd_cnt or last_q)
    begin
        if (rd_n_i === 1'b0 && rd_cnt >= RD_DLY)
            data_o = mem.exists(addr_i) ? mem[addr_i] : '0;
        else
            data_o = ~last_q;
    end
endmodule

// ---- testbench/shared_external_bus_port_test.sv ----
// Self-checking testbench for the shared external bus port
`timescale 1ns/10ps
module shared_external_bus_port_test;
    import sebp_pkg::*;
    typedef struct {logic [31:0] a; logic [3:0] sel; logic pg; logic rdn; logic wrn;} sebp_acc_t;
    logic              ref_clk_i = 1'b0;
    logic              resetn_i = 1'b0;
    logic              bus_master_i = 1'b1;
    sebp_sysctl_t      sysctl = '{5'h08, 5'h04, 32'h0000_1000};
    sebp_fmt_t         slave_fmt = FMT_W32;
    sebp_req_t         req = '0;
    logic              req_ready, data_oe, bsel_oe, rd_n_o, rd_oe, wr_n_o, wr_oe, page, page_oe;
    sebp_rsp_t         rsp;
    logic [31:0]       addr_i = '0;
    logic [31:0]       addr_o;
    logic              addr_oe;
    logic [47:0]       data_o, ext_data, sl_data = '0, sl_last = '0;
    logic              sl_drv = 1'b0, rd_n_i = 1'b1, wr_n_i = 1'b1;
    logic [3:0]        bsel_n;
    logic              ready_d = 1'b0, wr_d = 1'b1, oe_d = 1'b0, first_pg = 1'b1;
    logic [31:0]       last_pg = '0, ra;
    int                err_count = 0, check_count = 0;
    sebp_acc_t         acc_q[$], e;
    logic [47:0]       wr_q[$], sl_q[$];
    logic [39:0]       rd_q[$], w, v;

    always #50 ref_clk_i = ~ref_clk_i;

    sebp_port i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .bus_master_i(bus_master_i),
        .system_control_setting_i(sysctl), .slave_fmt_i(slave_fmt), .req_i(req),
        .req_ready_o(req_ready), .rsp_o(rsp), .addr_i(addr_i), .addr_o(addr_o),
        .addr_oe_o(addr_oe), .data_i(sl_drv ? sl_data : ext_data), .data_o(data_o),
        .data_oe_o(data_oe), .bank_select_n_o(bsel_n), .bank_select_oe_o(bsel_oe),
        .rd_n_i(rd_n_i), .rd_n_o(rd_n_o), .rd_oe_o(rd_oe), .wr_n_i(wr_n_i), .wr_n_o(wr_n_o),
        .wr_oe_o(wr_oe), .page_o(page), .page_oe_o(page_oe));

    sebp_ext_mem #(.RD_DLY(0)) i_mem (.ref_clk_i(ref_clk_i), .addr_i(addr_o), .data_i(data_o),
        .data_oe_i(data_oe), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .data_o(ext_data));

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("Checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [47:0] lanes(input sebp_fmt_t f, input logic [39:0] x);
        case (f)
            FMT_W32: return {x[31:0], 16'h0000};
            FMT_X40: return {x, 8'h00};
            FMT_S16: return {16'h0000, x[15:0], 16'h0000};
            default: return {24'h00_0000, x[7:0], 16'h0000};
        endcase
    endfunction

    function automatic logic [39:0] mask(input sebp_fmt_t f, input logic [39:0] x);
        case (f)
            FMT_W32: return {8'h00, x[31:0]};
            FMT_X40: return x;
            FMT_S16: return {24'h00_0000, x[15:0]};
            default: return {32'h0000_0000, x[7:0]};
        endcase
    endfunction

    // Expectations are queued before the request goes out
    task automatic acc(input logic wr, input logic cnd, input sebp_fmt_t f,
                       input logic [31:0] a, input logic [39:0] x);
        sebp_acc_t  t;
        logic [31:0] bk;
        logic       rdy;
        int         n;
        bk = (a - sysctl.ext_base) >> sysctl.bank_shift;
        t.a = a;
        t.sel = (a >= sysctl.ext_base && bk < 4) ? ~(4'h1 << bk[1:0]) : 4'hF;
        t.pg = 1'b0;
        if (t.sel == 4'hE)
        begin
            t.pg = first_pg || ((a >> sysctl.page_shift) != last_pg);
            first_pg = 1'b0;
            last_pg = a >> sysctl.page_shift;
        end
        t.rdn = wr || !cnd;
        t.wrn = !(wr && cnd);
        acc_q.push_back(t);
        if (!t.wrn)
            wr_q.push_back(lanes(f, x));
        if (!wr)
            rd_q.push_back(mask(f, x));
        @(posedge ref_clk_i);
        req <= '{1'b1, wr, cnd, f, a, x};
        n = 0;
        do
        begin
            @(negedge ref_clk_i);
            rdy = req_ready;
            @(posedge ref_clk_i);
            n++;
        end
        while (rdy !== 1'b1 && n < 50);
        if (n >= 50)
            check("req_ready_o", 48'(rdy), 48'h1);
        req.valid <= 1'b0;
    endtask

    task automatic sl_acc(input logic wr, input logic [31:0] a, input logic [47:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        sl_data <= d;
        sl_drv <= wr;
        if (wr)
            wr_n_i <= 1'b0;
        else
            rd_n_i <= 1'b0;
        repeat (wr ? 4 : 7) @(posedge ref_clk_i);
        wr_n_i <= 1'b1;
        rd_n_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        sl_drv <= 1'b0;
        sl_data <= ~d;
    endtask

    always @(negedge ref_clk_i)
    begin
        if (resetn_i === 1'b1)
        begin
            if (ready_d === 1'b1 && req_ready === 1'b0 && acc_q.size() > 0)
            begin
                e = acc_q.pop_front();
                check("bank_select_n_o", 48'(bsel_n), 48'(e.sel));
                check("addr_o", 48'(addr_o), 48'(e.a));
                check("page_o", 48'(page), 48'(e.pg));
                check("rd_n_o", 48'(rd_n_o), 48'(e.rdn));
                check("wr_n_o", 48'(wr_n_o), 48'(e.wrn));
            end
            if (ready_d === 1'b0 && req_ready === 1'b1)
                check("bank_select_n_o idle", 48'(bsel_n), 48'(BSEL_IDLE));
            if (wr_d === 1'b1 && wr_n_o === 1'b0)
                check("data_o write", data_o, wr_q.size() ? wr_q.pop_front() : ~data_o);
            if (rsp.valid === 1'b1)
                check("rsp_o.rdata", 48'(rsp.rdata), rd_q.size() ? 48'(rd_q.pop_front()) : '1);
            if (bus_master_i === 1'b0 && oe_d === 1'b1 && data_oe === 1'b0 && sl_q.size() > 0)
                check("data_o slave", sl_last, sl_q.pop_front());
        end
        ready_d = req_ready;
        wr_d = wr_n_o;
        oe_d = data_oe;
        if (data_oe === 1'b1)
            sl_last = data_o;
    end

    initial
    begin
        #(100 * 20000);
        err_count++;
        results();
    end

    initial
    begin
        w = $urandom(86739);
        repeat (8) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        // Each format in its own bank, write then read back, back to back
        for (int f = 0; f < 4; f++)
        begin
            w = {$urandom, $urandom};
            // Bank zero word is read back below through the wider lanes
            if (f == 0)
                v = w;
            acc(1'b1, 1'b1, sebp_fmt_t'(f), 32'h0000_1000 + 32'(f) * 32'h100 + 32'h10, w);
            acc(1'b0, 1'b1, sebp_fmt_t'(f), 32'h0000_1000 + 32'(f) * 32'h100 + 32'h10, w);
        end
        // Failed condition still selects the bank but leaves memory untouched
        acc(1'b1, 1'b0, FMT_W32, 32'h0000_1010, ~w);
        acc(1'b0, 1'b1, FMT_X40, 32'h0000_1010, {v[31:0], 8'h00});
        // Multiprocessor window and past the last bank: no select
        for (int i = 0; i < 2; i++)
        begin
            v = {$urandom, $urandom};
            acc(1'b1, 1'b1, FMT_X40, i ? 32'h0000_1400 : 32'h0000_0040, v);
            acc(1'b0, 1'b1, FMT_X40, i ? 32'h0000_1400 : 32'h0000_0040, v);
        end
        for (int i = 0; i < 6; i++)
        begin
            v = {$urandom, $urandom};
            ra = 32'h0000_1000 + ($urandom % 32'h400);
            acc(1'b1, 1'b1, sebp_fmt_t'(i % 4), ra, v);
            acc(1'b0, 1'b1, sebp_fmt_t'(i % 4), ra, v);
        end
        // Let the last access finish before giving up the bus
        repeat (6) @(posedge ref_clk_i);
        // Outside master reaches internal memory; our drivers let go of the bus
        bus_master_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        check("oe released", {43'h0, addr_oe, bsel_oe, rd_oe, wr_oe, page_oe}, 48'h0);
        for (int f = 0; f < 4; f++)
        begin
            slave_fmt <= sebp_fmt_t'(f);
            v = {$urandom, $urandom};
            sl_acc(1'b1, 32'h0000_0020 + 32'(f), lanes(sebp_fmt_t'(f), v));
            sl_acc(1'b1, 32'h0000_0120 + 32'(f), lanes(sebp_fmt_t'(f), ~v));
            sl_q.push_back(lanes(sebp_fmt_t'(f), v));
            sl_acc(1'b0, 32'h0000_0020 + 32'(f), '0);
        end
        bus_master_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        check("oe driven", {43'h0, addr_oe, bsel_oe, rd_oe, wr_oe, page_oe}, 48'h1F);
        check("queues drained", 48'(acc_q.size() + rd_q.size() + wr_q.size() + sl_q.size()), 48'h0);
        results();
    end
endmodule
